// >>> rtl/cfc_pkg.sv
// Constants for the clock fallback control block.
// Assumes a byte-wide register port with printed byte addresses and one core clock.
package cfc_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] FALLBACK_COMMAND_ADDR = 20'h0_0108;
    localparam logic [ADDR_W-1:0] FALLBACK_TYPE_SELECT_ADDR = 20'h0_0109;
    localparam logic [ADDR_W-1:0] FALLBACK_TRIGGER_ENABLE_LOW_ADDR = 20'h0_010A;
    localparam logic [ADDR_W-1:0] FALLBACK_TRIGGER_ENABLE_HIGH_ADDR = 20'h0_010B;
    localparam logic [ADDR_W-1:0] SYNC_OFFSET_LOW_ADDR = 20'h0_014A;
    localparam logic [ADDR_W-1:0] SYNC_OFFSET_HIGH_ADDR = 20'h0_014B;
    localparam logic [ADDR_W-1:0] FALLBACK_STATUS_ADDR = 20'h0_0150;

    // Command codes written to the fallback command register.
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_GO = 8'h01;
    localparam logic [7:0] CMD_CLEAR = 8'h02;
    localparam logic [7:0] CMD_FORCE = 8'h04;
    localparam logic [7:0] CMD_GO_SYNC = 8'h11;
    localparam logic [7:0] CMD_CLEAR_SYNC = 8'h12;
    localparam logic [7:0] CMD_FORCE_SYNC = 8'h14;
    localparam logic [7:0] CMD_COPY = 8'h20;

    // Fallback type select fields.
    localparam int SCHEME_MSB = 7;
    localparam int SCHEME_LSB = 4;
    localparam int POLICY_MSB = 3;
    localparam int POLICY_LSB = 0;
    localparam logic [3:0] SCHEME_NOP = 4'h0;
    localparam logic [3:0] SCHEME_OSC_DIV4 = 4'h1;
    localparam logic [3:0] SCHEME_MAIN_XY = 4'h2;
    localparam logic [3:0] SCHEME_BUS_AB = 4'h4;
    localparam logic [3:0] SCHEME_TRIG_REG = 4'h8;
    localparam logic [3:0] SCHEME_TRIG_REG_SM = 4'h9;
    localparam logic [3:0] POLICY_DISABLED = 4'h0;
    localparam logic [3:0] POLICY_FIXED = 4'h1;
    localparam logic [3:0] POLICY_ROTATING = 4'h2;

    // Trigger enable bit positions used by the bus A/B legacy scheme.
    localparam int LOW_C8A_BIT = 0;
    localparam int LOW_C8B_BIT = 1;
    localparam int HIGH_FRAME_A_BIT = 0;
    localparam int HIGH_FRAME_B_BIT = 1;
    localparam int HIGH_W = 7;

    // Reset values.
    localparam logic [7:0] TYPE_RESET = 8'h00;
    localparam logic [7:0] TRIG_LOW_RESET = 8'h00;
    localparam logic [HIGH_W-1:0] TRIG_HIGH_RESET = 7'h00;
    localparam logic [7:0] SYNC_OFFSET_RESET = 8'h00;

    // Operations that a framed command can hold as pending.
    typedef enum logic [1:0] {
        CFC_OP_GO,
        CFC_OP_CLEAR,
        CFC_OP_FORCE
    } cfc_op_t;

endpackage : cfc_pkg

// >>> rtl/cfc_clock_fallback_control.sv
// Clock fallback control: command register, fallback type, trigger enables
// and the active/inactive assignment of the X and Y clock register sets.
// Assumes the frame reference pulse and all failure flags come from logic
// on the core clock, one cycle wide for the frame pulse.
// Function
// - GO command activates X, immediate or framed.
// - CLEAR command, immediate or at frame.
// - FORCE command, immediate or at frame.
// - COPY code copies active set; zero nops.
// - Framed commands wait a programmable offset.
// - Upper nibble selects trigger scheme; legacy fixed.
// - Scheme 0001 falls back to oscillator/4.
// - Scheme 0010 main failure swaps sets.
// - Scheme 0100 bus A/B failure swaps sets.
// - Scheme 1000 trigger registers select inputs.
// - Scheme 1001 also enables bus state machine.
// - Policy 0000 never changes active set.
// - Fixed policy swaps, clear swaps back.
// - Rotating policy swaps, clear keeps swap.
// - Lower trigger enables, one per bus clock.
// - Upper trigger enables; bit 7 reads zero.
// - Enabled failing input raises fallback event.
// - Command register self-clears to no operation.
// - After reset Y active, access to X.
// - Framed command pends until frame reference.
// - Force creates event; clear ends it.
`timescale 1ns/1ps

module cfc_clock_fallback_control (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    // Register port
    input wire logic [cfc_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [cfc_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [cfc_pkg::DATA_W-1:0] REG_RDATA_OUT,
    // Frame reference and failure detectors
    input wire logic FRAME_REF_IN,
    input wire logic MAIN_CLK_FAIL_IN,
    input wire logic [7:0] BUS_CLK_FAIL_IN,
    input wire logic [cfc_pkg::HIGH_W-1:0] SYNC_FAIL_IN,
    // Clock set control
    output logic ACTIVE_SET_X_OUT,
    output logic ACCESS_SET_X_OUT,
    output logic COPY_ACTIVE_OUT,
    output logic FALLBACK_ACTIVE_OUT,
    output logic FALLBACK_EVENT_OUT,
    output logic OSC_DIV4_FALLBACK_OUT,
    output logic BUS_CLK_SM_EN_OUT
);
    import cfc_pkg::*;

    typedef struct packed {
        logic [7:0] type_sel;
        logic [7:0] trig_low;
        logic [HIGH_W-1:0] trig_high;
        logic [7:0] sync_offset_low;
        logic [7:0] sync_offset_high;
        logic active_x;
        logic fb_flag;
        logic osc_fb;
        logic pend_valid;
        cfc_op_t pend_op;
        logic offs_run;
        logic [15:0] offs_cnt;
        logic main_fail_prev;
        logic [7:0] bus_fail_prev;
        logic [HIGH_W-1:0] sync_fail_prev;
        logic copy_pulse;
        logic event_pulse;
        logic [7:0] rdata;
    } cfc_state_t;

    cfc_state_t s;
    cfc_state_t next_s;

    logic [3:0] scheme;
    logic [3:0] policy;
    logic swap_enabled;
    logic [15:0] sync_offset;
    logic [7:0] bus_rise;
    logic [HIGH_W-1:0] sync_rise;
    logic main_rise;
    logic trig_event;
    logic do_go;
    logic do_clear;
    logic do_force;
    logic exec_pend;
    logic cmd_wr;

    assign scheme = s.type_sel[SCHEME_MSB:SCHEME_LSB];
    assign policy = s.type_sel[POLICY_MSB:POLICY_LSB];
    assign sync_offset = {s.sync_offset_high, s.sync_offset_low};
    // Write strobe aimed at the command register. The register keeps no
    // value; immediate commands act on this one-cycle strobe, framed ones are held as pending.
    assign cmd_wr = REG_WR_IN && (REG_ADDR_IN == FALLBACK_COMMAND_ADDR);

    // swapping policy only.
    // Disabled and undefined policies both leave the active set alone.
    assign swap_enabled = (policy == POLICY_FIXED) || (policy == POLICY_ROTATING);

    // Failures are acted on at their rising edge, so a detector that stays
    // failed does not keep re-firing after software clears the fallback.
    assign main_rise = MAIN_CLK_FAIL_IN & ~s.main_fail_prev;
    assign bus_rise = BUS_CLK_FAIL_IN & ~s.bus_fail_prev;
    assign sync_rise = SYNC_FAIL_IN & ~s.sync_fail_prev;

    always_comb begin
        trig_event = 1'b0;
        unique case (scheme)
            SCHEME_MAIN_XY: begin
                trig_event = main_rise;
            end
            SCHEME_BUS_AB: begin
                trig_event = bus_rise[LOW_C8A_BIT] | bus_rise[LOW_C8B_BIT] |
                    sync_rise[HIGH_FRAME_A_BIT] | sync_rise[HIGH_FRAME_B_BIT];
            end
            SCHEME_TRIG_REG, SCHEME_TRIG_REG_SM: begin
                trig_event = (|(bus_rise & s.trig_low)) | (|(sync_rise & s.trig_high));
            end
            default: begin
                // nop and oscillator schemes raise no set event.
                trig_event = 1'b0;
            end
        endcase
    end

    // pending command release.
    // A pending command fires at the frame pulse when the offset is zero,
    // otherwise that many core cycles after the frame pulse.
    // Frame pulses that arrive while the offset is counting are ignored,
    // so a short frame period cannot restart the count and starve the command.
    always_comb begin
        exec_pend = 1'b0;
        if (s.pend_valid && s.offs_run && s.offs_cnt == 16'h0001) begin
            exec_pend = 1'b1;
        end else if (s.pend_valid && !s.offs_run && FRAME_REF_IN &&
                     sync_offset == 16'h0000) begin
            exec_pend = 1'b1;
        end
    end

    // Decode of immediate commands and of a released pending command.
    // Both may fall in one cycle; then both are applied, GO ahead of any
    // event swap, except that a FORCE with a CLEAR leaves the fallback flag set.
    always_comb begin
        do_go = 1'b0;
        do_clear = 1'b0;
        do_force = 1'b0;
        if (exec_pend) begin
            unique case (s.pend_op)
                CFC_OP_GO: begin
                    do_go = 1'b1;
                end
                CFC_OP_CLEAR: begin
                    do_clear = 1'b1;
                end
                CFC_OP_FORCE: begin
                    do_force = 1'b1;
                end
            endcase
        end
        if (cmd_wr) begin
            unique case (REG_WDATA_IN)
                CMD_GO: begin
                    do_go = 1'b1;
                end
                CMD_CLEAR: begin
                    do_clear = 1'b1;
                end
                CMD_FORCE: begin
                    do_force = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_s = s;
        next_s.copy_pulse = 1'b0;
        next_s.event_pulse = 1'b0;
        next_s.rdata = 8'h00;
        next_s.main_fail_prev = MAIN_CLK_FAIL_IN;
        next_s.bus_fail_prev = BUS_CLK_FAIL_IN;
        next_s.sync_fail_prev = SYNC_FAIL_IN;

        // offset countdown.
        // The counter is loaded at the frame pulse and the command runs when
        // it reaches one, that many cycles after the pulse.
        if (exec_pend) begin
            next_s.pend_valid = 1'b0;
            next_s.offs_run = 1'b0;
            next_s.offs_cnt = 16'h0000;
        end else if (s.pend_valid && s.offs_run) begin
            next_s.offs_cnt = s.offs_cnt - 16'h0001;
        end else if (s.pend_valid && FRAME_REF_IN) begin
            next_s.offs_run = 1'b1;
            next_s.offs_cnt = sync_offset;
        end

        // Register writes.
        // Unmapped addresses are ignored; the command register stores nothing.
        if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                FALLBACK_COMMAND_ADDR: begin
                    // the register holds no value, so it
                    // reads as no operation right after the write.
                    // A new framed command replaces any pending one and waits
                    // for the next frame again, even if a count was running.
                    unique case (REG_WDATA_IN)
                        CMD_GO_SYNC: begin
                            next_s.pend_valid = 1'b1;
                            next_s.pend_op = CFC_OP_GO;
                            next_s.offs_run = 1'b0;
                        end
                        CMD_CLEAR_SYNC: begin
                            next_s.pend_valid = 1'b1;
                            next_s.pend_op = CFC_OP_CLEAR;
                            next_s.offs_run = 1'b0;
                        end
                        CMD_FORCE_SYNC: begin
                            next_s.pend_valid = 1'b1;
                            next_s.pend_op = CFC_OP_FORCE;
                            next_s.offs_run = 1'b0;
                        end
                        CMD_COPY: begin
                            next_s.copy_pulse = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
                FALLBACK_TYPE_SELECT_ADDR: begin
                    next_s.type_sel = REG_WDATA_IN;
                end
                FALLBACK_TRIGGER_ENABLE_LOW_ADDR: begin
                    next_s.trig_low = REG_WDATA_IN;
                end
                FALLBACK_TRIGGER_ENABLE_HIGH_ADDR: begin
                    next_s.trig_high = REG_WDATA_IN[HIGH_W-1:0];
                end
                SYNC_OFFSET_LOW_ADDR: begin
                    next_s.sync_offset_low = REG_WDATA_IN;
                end
                SYNC_OFFSET_HIGH_ADDR: begin
                    next_s.sync_offset_high = REG_WDATA_IN;
                end
                default: begin
                end
            endcase
        end

        // oscillator fallback latch.
        // A new main failure in the same cycle as a clear keeps the latch set.
        if (scheme == SCHEME_OSC_DIV4 && main_rise) begin
            next_s.osc_fb = 1'b1;
        end else if (do_clear) begin
            next_s.osc_fb = 1'b0;
        end

        if (do_go) begin
            next_s.active_x = 1'b1;
        end

        // fallback event.
        // An event in the same cycle as a clear wins, so it is never lost.
        // A second event while already in fallback does not swap again, so
        // the fixed policy always has exactly one swap to undo on clear.
        if (do_force || trig_event) begin
            next_s.event_pulse = 1'b1;
            next_s.fb_flag = 1'b1;
            if (swap_enabled && !s.fb_flag) begin
                next_s.active_x = ~next_s.active_x;
            end
        end else if (do_clear && s.fb_flag) begin
            next_s.fb_flag = 1'b0;
            if (policy == POLICY_FIXED) begin
                next_s.active_x = ~next_s.active_x;
            end
        end

        // Register reads; data stands in the next cycle only.
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                FALLBACK_TYPE_SELECT_ADDR: begin
                    next_s.rdata = s.type_sel;
                end
                FALLBACK_TRIGGER_ENABLE_LOW_ADDR: begin
                    next_s.rdata = s.trig_low;
                end
                FALLBACK_TRIGGER_ENABLE_HIGH_ADDR: begin
                    next_s.rdata = {1'b0, s.trig_high};
                end
                SYNC_OFFSET_LOW_ADDR: begin
                    next_s.rdata = s.sync_offset_low;
                end
                SYNC_OFFSET_HIGH_ADDR: begin
                    next_s.rdata = s.sync_offset_high;
                end
                // The status byte is read-only and shows pending, oscillator,
                // fallback and active-set state in one access.
                FALLBACK_STATUS_ADDR: begin
                    next_s.rdata = {4'h0, s.pend_valid, s.osc_fb, s.fb_flag, s.active_x};
                end
                default: begin
                    next_s.rdata = CMD_NOP;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            // Failure history resets low, so a detector that is already
            // failed when reset ends is taken as a fresh failure.
            s.type_sel <= TYPE_RESET;
            s.trig_low <= TRIG_LOW_RESET;
            s.trig_high <= TRIG_HIGH_RESET;
            s.sync_offset_low <= SYNC_OFFSET_RESET;
            s.sync_offset_high <= SYNC_OFFSET_RESET;
            s.active_x <= 1'b0;
            s.fb_flag <= 1'b0;
            s.osc_fb <= 1'b0;
            s.pend_valid <= 1'b0;
            s.pend_op <= CFC_OP_GO;
            s.offs_run <= 1'b0;
            s.offs_cnt <= 16'h0000;
            s.main_fail_prev <= 1'b0;
            s.bus_fail_prev <= 8'h00;
            s.sync_fail_prev <= 7'h00;
            s.copy_pulse <= 1'b0;
            s.event_pulse <= 1'b0;
            s.rdata <= 8'h00;
        end else begin
            s <= next_s;
        end
    end

    assign REG_RDATA_OUT = s.rdata;
    assign ACTIVE_SET_X_OUT = s.active_x;
    assign ACCESS_SET_X_OUT = ~s.active_x;
    assign COPY_ACTIVE_OUT = s.copy_pulse;
    assign FALLBACK_ACTIVE_OUT = s.fb_flag;
    assign FALLBACK_EVENT_OUT = s.event_pulse;
    assign OSC_DIV4_FALLBACK_OUT = s.osc_fb;
    // bus state machine enable.
    // Decoded straight from the type register, so it follows a write one
    // cycle later with no state of its own.
    assign BUS_CLK_SM_EN_OUT = (scheme == SCHEME_TRIG_REG_SM);

endmodule : cfc_clock_fallback_control

// >>> dv/cfc_clock_fallback_control_chk.sv
// Port checker for the clock fallback control block.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/1ps

module cfc_chk (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    // Register port
    input wire logic [cfc_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [cfc_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [cfc_pkg::DATA_W-1:0] REG_RDATA_OUT,
    // Detectors
    input wire logic FRAME_REF_IN,
    input wire logic MAIN_CLK_FAIL_IN,
    input wire logic [7:0] BUS_CLK_FAIL_IN,
    input wire logic [cfc_pkg::HIGH_W-1:0] SYNC_FAIL_IN,
    // Set control
    input wire logic ACTIVE_SET_X_OUT,
    input wire logic ACCESS_SET_X_OUT,
    input wire logic COPY_ACTIVE_OUT,
    input wire logic FALLBACK_ACTIVE_OUT,
    input wire logic FALLBACK_EVENT_OUT,
    input wire logic OSC_DIV4_FALLBACK_OUT,
    input wire logic BUS_CLK_SM_EN_OUT
);
    import cfc_pkg::*;
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    // A failure edge in the same cycle may legally override a command.
    logic quiet;
    assign quiet = !FRAME_REF_IN && !MAIN_CLK_FAIL_IN && BUS_CLK_FAIL_IN == 8'h00
        && SYNC_FAIL_IN == 7'h00;
    sequence s_cmd(logic [7:0] c);
        REG_WR_IN && REG_ADDR_IN == FALLBACK_COMMAND_ADDR && REG_WDATA_IN == c && quiet;
    endsequence
    sequence s_pulse(logic p);
        p ##1 !p;
    endsequence
    access_tracks_a: assert property (ACCESS_SET_X_OUT == !ACTIVE_SET_X_OUT)
        else $error("access select not opposite of active set");
    go_sets_x_a: assert property (s_cmd(CMD_GO) |=> ACTIVE_SET_X_OUT)
        else $error("go command did not activate set x");
    copy_pulse_a: assert property (
        s_cmd(CMD_COPY) ##1 !REG_WR_IN |-> s_pulse(COPY_ACTIVE_OUT))
        else $error("copy pulse missing or too long");
    force_event_a: assert property (
        s_cmd(CMD_FORCE) |=> FALLBACK_EVENT_OUT && FALLBACK_ACTIVE_OUT)
        else $error("force command raised no fallback");
    clear_ends_a: assert property (
        s_cmd(CMD_CLEAR) |=> !FALLBACK_ACTIVE_OUT && !OSC_DIV4_FALLBACK_OUT)
        else $error("clear command left fallback set");
    framed_wait_a: assert property (
        s_cmd(CMD_FORCE_SYNC) |=> !FALLBACK_EVENT_OUT && $stable(ACTIVE_SET_X_OUT))
        else $error("framed command acted without frame");
    cmd_reads_zero_a: assert property (
        REG_RD_IN && REG_ADDR_IN == FALLBACK_COMMAND_ADDR |=> REG_RDATA_OUT == 8'h00)
        else $error("command register read not zero");
    high_bit7_a: assert property (
        REG_RD_IN && REG_ADDR_IN == FALLBACK_TRIGGER_ENABLE_HIGH_ADDR |=> !REG_RDATA_OUT[7])
        else $error("reserved trigger bit read as one");
    sm_enable_a: assert property (
        REG_WR_IN && REG_ADDR_IN == FALLBACK_TYPE_SELECT_ADDR |=>
        BUS_CLK_SM_EN_OUT == ($past(REG_WDATA_IN[SCHEME_MSB:SCHEME_LSB]) == SCHEME_TRIG_REG_SM))
        else $error("state machine enable does not follow scheme");
    osc_cause_a: assert property ($rose(OSC_DIV4_FALLBACK_OUT) |-> $past(MAIN_CLK_FAIL_IN))
        else $error("oscillator fallback without main failure");
endmodule : cfc_chk

bind cfc_clock_fallback_control cfc_chk u_cfc_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .FRAME_REF_IN(FRAME_REF_IN),
    .MAIN_CLK_FAIL_IN(MAIN_CLK_FAIL_IN), .BUS_CLK_FAIL_IN(BUS_CLK_FAIL_IN),
    .SYNC_FAIL_IN(SYNC_FAIL_IN), .ACTIVE_SET_X_OUT(ACTIVE_SET_X_OUT),
    .ACCESS_SET_X_OUT(ACCESS_SET_X_OUT), .COPY_ACTIVE_OUT(COPY_ACTIVE_OUT),
    .FALLBACK_ACTIVE_OUT(FALLBACK_ACTIVE_OUT), .FALLBACK_EVENT_OUT(FALLBACK_EVENT_OUT),
    .OSC_DIV4_FALLBACK_OUT(OSC_DIV4_FALLBACK_OUT), .BUS_CLK_SM_EN_OUT(BUS_CLK_SM_EN_OUT)
);

// >>> dv/tb_cfc_clock_fallback_control.sv
// Self-checking bench for the clock fallback control block.
// Assumes the bench alone drives every input; the checker is bound on its own.
`timescale 1ns/1ps

module tb_cfc_clock_fallback_control;
    import cfc_pkg::*;
    localparam logic [19:0] a_cmd = FALLBACK_COMMAND_ADDR;
    localparam logic [19:0] a_typ = FALLBACK_TYPE_SELECT_ADDR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [19:0] ad = 20'h0_0000;
    logic [7:0] wd = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic fr = 1'b0;
    logic mf = 1'b0;
    logic [7:0] bf = 8'h00;
    logic [6:0] sf = 7'h00;
    logic [7:0] rdata;
    logic act, acc, cp, fb, ev, osc, sm;
    int miscompares = 0;
    int n_compared = 0;

    always #2.5 clk = ~clk;

    cfc_clock_fallback_control u_cfc_clock_fallback_control (
        .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(ad), .REG_WDATA_IN(wd),
        .REG_WR_IN(we), .REG_RD_IN(re), .REG_RDATA_OUT(rdata), .FRAME_REF_IN(fr),
        .MAIN_CLK_FAIL_IN(mf), .BUS_CLK_FAIL_IN(bf), .SYNC_FAIL_IN(sf),
        .ACTIVE_SET_X_OUT(act), .ACCESS_SET_X_OUT(acc), .COPY_ACTIVE_OUT(cp),
        .FALLBACK_ACTIVE_OUT(fb), .FALLBACK_EVENT_OUT(ev),
        .OSC_DIV4_FALLBACK_OUT(osc), .BUS_CLK_SM_EN_OUT(sm)
    );

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so it is sampled there.
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge clk);
        ad <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
    endtask : do_reset

    task automatic frame;
        @(posedge clk);
        fr <= 1'b1;
        @(posedge clk);
        fr <= 1'b0;
        #1;
    endtask : frame

    task automatic t_regs;
        do_reset();
        chk(8'(act), 8'h00);
        chk(8'(acc), 8'h01);
        rd(a_typ, 8'h00);
        rd(FALLBACK_TRIGGER_ENABLE_LOW_ADDR, 8'h00);
        rd(FALLBACK_TRIGGER_ENABLE_HIGH_ADDR, 8'h00);
        wr(FALLBACK_TRIGGER_ENABLE_HIGH_ADDR, 8'hFF);
        rd(FALLBACK_TRIGGER_ENABLE_HIGH_ADDR, 8'h7F);
        wr(FALLBACK_TRIGGER_ENABLE_LOW_ADDR, 8'hA5);
        rd(FALLBACK_TRIGGER_ENABLE_LOW_ADDR, 8'hA5);
        wr(SYNC_OFFSET_HIGH_ADDR, 8'h5A);
        rd(SYNC_OFFSET_HIGH_ADDR, 8'h5A);
        wr(a_cmd, CMD_NOP);
        rd(a_cmd, 8'h00);
        chk(8'(act), 8'h00);
        rd(20'h0_01FF, 8'h00);
    endtask : t_regs

    task automatic t_go;
        do_reset();
        wr(a_cmd, CMD_GO);
        chk(8'(act), 8'h01);
        wr(a_cmd, CMD_COPY);
        chk(8'(cp), 8'h01);
        cyc(1);
        chk(8'(cp), 8'h00);
        wr(a_cmd, 8'h03);
        chk(8'(act), 8'h01);
        chk(8'(ev), 8'h00);
    endtask : t_go

    task automatic t_pol(input logic [3:0] pol, input logic ef, input logic ec);
        do_reset();
        wr(a_typ, {SCHEME_NOP, pol});
        wr(a_cmd, CMD_FORCE);
        chk(8'(ev), 8'h01);
        chk(8'(fb), 8'h01);
        chk(8'(act), 8'(ef));
        wr(a_cmd, CMD_CLEAR);
        chk(8'(fb), 8'h00);
        chk(8'(act), 8'(ec));
    endtask : t_pol

    task automatic t_sync;
        do_reset();
        wr(a_typ, {SCHEME_NOP, POLICY_FIXED});
        wr(a_cmd, CMD_FORCE_SYNC);
        cyc(4);
        chk(8'(fb), 8'h00);
        frame();
        chk(8'(fb), 8'h01);
        chk(8'(act), 8'h01);
        rd(FALLBACK_STATUS_ADDR, 8'h03);
        wr(SYNC_OFFSET_LOW_ADDR, 8'h03);
        wr(a_cmd, CMD_CLEAR_SYNC);
        frame();
        cyc(2);
        chk(8'(fb), 8'h01);
        cyc(1);
        chk(8'(fb), 8'h00);
        chk(8'(act), 8'h00);
        wr(SYNC_OFFSET_LOW_ADDR, 8'h00);
        wr(a_cmd, CMD_GO_SYNC);
        chk(8'(act), 8'h00);
        rd(FALLBACK_STATUS_ADDR, 8'h08);
        frame();
        chk(8'(act), 8'h01);
    endtask : t_sync

    // Raises the given failures, judges the outcome, then drops them and clears.
    task automatic fail_in(input logic m, input logic [7:0] b, input logic [6:0] s,
                           input logic e, input logic o);
        @(posedge clk);
        mf <= m;
        bf <= b;
        sf <= s;
        cyc(1);
        chk(8'(ev), 8'(e));
        cyc(1);
        chk(8'(fb), 8'(e));
        chk(8'(act), 8'(e));
        chk(8'(osc), 8'(o));
        @(posedge clk);
        mf <= 1'b0;
        bf <= 8'h00;
        sf <= 7'h00;
        wr(a_cmd, CMD_CLEAR);
    endtask : fail_in

    task automatic t_trig;
        do_reset();
        wr(a_typ, {SCHEME_TRIG_REG, POLICY_FIXED});
        wr(FALLBACK_TRIGGER_ENABLE_LOW_ADDR, 8'h04);
        wr(FALLBACK_TRIGGER_ENABLE_HIGH_ADDR, 8'h40);
        fail_in(1'b0, 8'h08, 7'h00, 1'b0, 1'b0);
        fail_in(1'b0, 8'h04, 7'h00, 1'b1, 1'b0);
        fail_in(1'b0, 8'h00, 7'h40, 1'b1, 1'b0);
        wr(a_typ, {SCHEME_BUS_AB, POLICY_FIXED});
        fail_in(1'b0, 8'h04, 7'h00, 1'b0, 1'b0);
        fail_in(1'b0, 8'h01, 7'h00, 1'b1, 1'b0);
        fail_in(1'b0, 8'h00, 7'h02, 1'b1, 1'b0);
        wr(a_typ, {SCHEME_MAIN_XY, POLICY_FIXED});
        fail_in(1'b1, 8'h00, 7'h00, 1'b1, 1'b0);
        wr(a_typ, {SCHEME_OSC_DIV4, POLICY_FIXED});
        chk(8'(sm), 8'h00);
        fail_in(1'b1, 8'h00, 7'h00, 1'b0, 1'b1);
        chk(8'(osc), 8'h00);
        wr(a_typ, {SCHEME_TRIG_REG_SM, POLICY_FIXED});
        chk(8'(sm), 8'h01);
        fail_in(1'b0, 8'h04, 7'h00, 1'b1, 1'b0);
        wr(a_typ, {SCHEME_NOP, POLICY_FIXED});
        fail_in(1'b1, 8'hFF, 7'h7F, 1'b0, 1'b0);
    endtask : t_trig

    initial begin
        t_regs();
        t_go();
        t_pol(POLICY_DISABLED, 1'b0, 1'b0);
        t_pol(POLICY_FIXED, 1'b1, 1'b0);
        t_pol(POLICY_ROTATING, 1'b1, 1'b1);
        t_pol(4'h3, 1'b0, 1'b0);
        t_sync();
        t_trig();
        stop_test();
    end

    // The sequence needs well under a thousand cycles.
    initial begin
        #50000;
        miscompares++;
        stop_test();
    end
endmodule : tb_cfc_clock_fallback_control
